/* File: src/selfdiag_pkg.sv */
/*
 * Constants for the power-on self-diagnosis of the threshold switch:
 * timing figures in microseconds, cycle counts derived for the clock.
 * Assumes a single 100 MHz clock.
 */
package selfdiag_pkg;

    // ***************************************************************
    // Clock
    // ***************************************************************
    localparam int CLK_MHZ           = 100;

    // ***************************************************************
    // Timing figures in us
    // ***************************************************************
    localparam int HOLD_MIN_US       = 20;
    localparam int FALL_TYP_US       = 10;
    localparam int RISE_TYP_US       = 10;
    localparam int FIRST_OUT_TYP_US  = 30;
    localparam int PLAIN_PO_TYP_US   = 20;

    // ***************************************************************
    // Derived cycle counts (must fit CNT_W bits, passed as top parameters)
    // ***************************************************************
    localparam int HOLD_MIN_CYC      = HOLD_MIN_US * CLK_MHZ;
    localparam int FALL_TYP_CYC      = FALL_TYP_US * CLK_MHZ;
    localparam int RISE_TYP_CYC      = RISE_TYP_US * CLK_MHZ;
    localparam int FIRST_OUT_TYP_CYC = FIRST_OUT_TYP_US * CLK_MHZ;
    localparam int PLAIN_PO_TYP_CYC  = PLAIN_PO_TYP_US * CLK_MHZ;

    localparam int CNT_W             = 16;

    typedef enum logic [2:0] {
        ST_POWERUP  = 3'b000,
        ST_RELEASED = 3'b001,
        ST_DUMMY_LO = 3'b011,
        ST_DUMMY_HI = 3'b010,
        ST_NORMAL   = 3'b110
    } diag_state_t;

endpackage

/* File: src/field_if.sv */
/*
 * Interface between the sequencer and its field comparator.
 * Assumes both ends share clk_i.
 */
`timescale 1ns/10ps
interface field_if;
    logic above_op;
    logic below_rel;
    logic drive_low;
    modport cmp (input above_op, input below_rel, output drive_low);
    modport seq (output above_op, output below_rel, input drive_low);
endinterface

/* File: src/field_hysteresis.sv */
/*
 * Hysteresis comparator: output driver on above operate threshold,
 * off below release threshold, held otherwise.
 * Assumes threshold flags synchronous to clk_i.
 */
`timescale 1ns/10ps
module field_hysteresis (
    input  wire logic clk_i,
    input  wire logic srst_i,
    field_if.cmp      fld
);
    logic drv_q;
    logic drv_d;

    always_comb begin
        drv_d = drv_q;
        if (fld.above_op) begin
            drv_d = 1'b1; // RULE9
        end else if (fld.below_rel) begin
            drv_d = 1'b0; // RULE9
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            drv_q <= 1'b0;
        end else begin
            drv_q <= drv_d;
        end
    end

    assign fld.drive_low = drv_q;

    property p_hyst;
        @(posedge clk_i) disable iff (srst_i)
        fld.above_op |=> fld.drive_low;
    endproperty
    a_hyst: assert property (p_hyst) else $error("driver not on above threshold"); // RULE9

    property p_hyst_off;
        @(posedge clk_i) disable iff (srst_i)
        (fld.below_rel && !fld.above_op) |=> !fld.drive_low;
    endproperty
    a_hyst_off: assert property (p_hyst_off) else $error("driver on below release"); // RULE9
endmodule

/* File: src/selfdiag_top.sv */
/*
 * Power-on self-diagnosis sequencer of an open-drain threshold switch.
 * Assumes srst_i is the supply-good reset (rail at 90%), out_line_i is
 * the sensed level of the open-drain line, synchronous to clk_i.
 */
// Summary of operation
// [RULE1] Host powers sensor off and holds output line low to request diagnosis.
// [RULE2] Host powers on, holds low, releases no earlier than 20 us later.
// [RULE3] Line not held low through power-up, or released early: normal switching.
// [RULE4] After release sensor leaves line undriven so pull-up raises it.
// [RULE5] Sensor drives line low 5 to 15 us after release, typically 10.
// [RULE6] Sensor releases line 5 to 15 us after falling edge, typically 10.
// [RULE7] Then normal output, first real output 15 to 45 us after release.
// [RULE8] Host timestamps both dummy edges and checks their windows.
// [RULE9] Normal mode: driver on above operate, off below release threshold.
// [RULE10] Without diagnosis, valid output within 30 us of power-on.
// [RULE11] Host flags failure on missing or late dummy edge.
`timescale 1ns/10ps
module selfdiag_top
    import selfdiag_pkg::*;
#(
    parameter int HOLD_CYC  = HOLD_MIN_CYC,
    parameter int FALL_CYC  = FALL_TYP_CYC,
    parameter int RISE_CYC  = RISE_TYP_CYC,
    parameter int FIRST_CYC = FIRST_OUT_TYP_CYC,
    parameter int PO_CYC    = PLAIN_PO_TYP_CYC
) (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic out_line_i,
    input  wire logic field_above_op_i,
    input  wire logic field_below_rel_i,
    output logic      out_line_o,
    output logic      out_line_oe_o,
    output logic      diag_active_o,
    output logic      normal_mode_o
);

    // ***************************************************************
    // Comparator
    // ***************************************************************
    field_if fld ();
    assign fld.above_op  = field_above_op_i;
    assign fld.below_rel = field_below_rel_i;

    field_hysteresis u_cmp (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .fld    (fld)
    );

    // ***************************************************************
    // Sequencer
    // ***************************************************************
    diag_state_t        st_q;
    diag_state_t        st_d;
    logic [CNT_W-1:0]   cnt_q;
    logic [CNT_W-1:0]   cnt_d;
    logic               oe_q;
    logic               oe_d;

    function automatic logic reached(input logic [CNT_W-1:0] c, input int lim);
        reached = (32'(c) >= lim - 1);
    endfunction

    function automatic logic in_dummy(input diag_state_t s);
        in_dummy = (s == ST_DUMMY_LO) || (s == ST_DUMMY_HI);
    endfunction

    always_comb begin
        st_d  = st_q;
        oe_d  = 1'b0;
        cnt_d = cnt_q + CNT_W'(1);
        case (st_q)
            ST_POWERUP: begin
                // Line high during power-up means no request
                if (out_line_i) begin
                    if (reached(cnt_q, PO_CYC)) begin
                        st_d  = ST_NORMAL; // RULE3 RULE10
                        cnt_d = '0;
                    end
                end else if (reached(cnt_q, HOLD_CYC)) begin
                    st_d  = ST_RELEASED;
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            ST_RELEASED: begin
                // Wait for host release, then the fall delay
                if (!out_line_i) begin
                    cnt_d = '0; // RULE4
                end else if (reached(cnt_q, FALL_CYC)) begin
                    st_d  = ST_DUMMY_LO; // RULE5
                    oe_d  = 1'b1;
                    cnt_d = '0;
                end
            end
            ST_DUMMY_LO: begin
                oe_d = 1'b1;
                if (reached(cnt_q, RISE_CYC)) begin
                    st_d  = ST_DUMMY_HI; // RULE6
                    oe_d  = 1'b0;
                    cnt_d = '0;
                end
            end
            ST_DUMMY_HI: begin
                if (reached(cnt_q, FIRST_CYC - FALL_CYC - RISE_CYC)) begin
                    st_d  = ST_NORMAL; // RULE7
                    cnt_d = '0;
                end
            end
            ST_NORMAL: begin
                cnt_d = '0;
                oe_d  = fld.drive_low; // RULE9
            end
            default: begin
                st_d  = ST_POWERUP;
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_q  <= ST_POWERUP;
            cnt_q <= '0;
            oe_q  <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            oe_q  <= oe_d;
        end
    end

    // Open drain: data is always low, only the enable moves
    assign out_line_o    = 1'b0;
    assign out_line_oe_o = oe_q;
    assign diag_active_o = (st_q == ST_RELEASED) || in_dummy(st_q);
    assign normal_mode_o = (st_q == ST_NORMAL);

    // ***************************************************************
    // Checks
    // ***************************************************************
    // Cycles since the host release was last seen, kept apart from
    // cnt_q so the edge timing is judged against an independent count
    logic [CNT_W-1:0]   since_rel_q;
    logic [CNT_W-1:0]   since_rel_d;

    always_comb begin
        since_rel_d = '0;
        if ((st_q == ST_RELEASED && out_line_i) || in_dummy(st_q)) begin
            since_rel_d = since_rel_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            since_rel_q <= '0;
        end else begin
            since_rel_q <= since_rel_d;
        end
    end

    sequence s_fall;
        $rose(st_q == ST_DUMMY_LO);
    endsequence

    sequence s_rise;
        $fell(st_q == ST_DUMMY_LO);
    endsequence

    sequence s_first;
        $rose(normal_mode_o) && ($past(st_q) == ST_DUMMY_HI);
    endsequence

    property p_undriven;
        @(posedge clk_i) disable iff (srst_i)
        (st_q == ST_RELEASED) |-> !oe_q;
    endproperty
    a_undriven: assert property (p_undriven) else $error("line driven before dummy fall"); // RULE4

    property p_fall;
        @(posedge clk_i) disable iff (srst_i)
        (st_q == ST_DUMMY_LO) |-> oe_q;
    endproperty
    a_fall: assert property (p_fall) else $error("dummy low not driven"); // RULE5

    property p_rise;
        @(posedge clk_i) disable iff (srst_i)
        s_rise |-> (since_rel_q == CNT_W'(FALL_CYC + RISE_CYC));
    endproperty
    a_rise: assert property (p_rise) else $error("dummy low phase broken"); // RULE6

    property p_fall_time;
        @(posedge clk_i) disable iff (srst_i)
        s_fall |-> (since_rel_q == CNT_W'(FALL_CYC));
    endproperty
    a_fall_time: assert property (p_fall_time) else $error("dummy fall off time"); // RULE5

    property p_first_time;
        @(posedge clk_i) disable iff (srst_i)
        s_first |-> (since_rel_q == CNT_W'(FIRST_CYC));
    endproperty
    a_first_time: assert property (p_first_time) else $error("first output off time"); // RULE7

    property p_after;
        @(posedge clk_i) disable iff (srst_i)
        $fell(st_q == ST_DUMMY_LO) |-> !oe_q;
    endproperty
    a_after: assert property (p_after) else $error("line still driven after dummy rise"); // RULE6

    property p_normal;
        @(posedge clk_i) disable iff (srst_i)
        $rose(normal_mode_o) |-> $past(st_q) != ST_DUMMY_LO;
    endproperty
    a_normal: assert property (p_normal) else $error("normal entered from dummy low"); // RULE7

    property p_nodiag;
        @(posedge clk_i) disable iff (srst_i)
        (st_q == ST_NORMAL) |=> (st_q == ST_NORMAL);
    endproperty
    a_nodiag: assert property (p_nodiag) else $error("left normal mode"); // RULE3

    property p_follow;
        @(posedge clk_i) disable iff (srst_i)
        (st_q == ST_NORMAL) ##1 (st_q == ST_NORMAL) |-> oe_q == $past(fld.drive_low);
    endproperty
    a_follow: assert property (p_follow) else $error("output not following field"); // RULE9

    property p_po;
        @(posedge clk_i) disable iff (srst_i)
        (st_q == ST_POWERUP) |-> !oe_q;
    endproperty
    a_po: assert property (p_po) else $error("driven during power-up"); // RULE10

endmodule

/* File: test/host_model.sv */
/*
 * Host that pulls the output line and stamps the dummy edges.
 * Assumes the bench forms the wired line from all pull enables.
 */
`timescale 1ns/10ps
module host_model #(
    parameter int FALL = 10,
    parameter int RISE = 10
) (
    input  wire logic        clk_i,
    input  wire logic        hold_i,
    input  wire logic        line_i,
    output logic             pull_o,
    output logic [15:0]      t_fall_o,
    output logic [15:0]      t_rise_o,
    output logic             ok_o
);
    // ***************************************************************
    // Pull and edge timestamps
    // ***************************************************************
    logic        line_q;
    logic [15:0] cnt_q;
    logic [15:0] fall_q;
    logic [15:0] rise_q;
    assign pull_o = hold_i;
    // Only the first fall and rise after release are stamped, so later
    // field switching cannot overwrite the diagnosis result
    always_ff @(posedge clk_i) begin
        line_q <= line_i;
        cnt_q  <= hold_i ? 16'h0000 : cnt_q + 16'h0001;
        if (hold_i) begin
            fall_q <= 16'h0000;
            rise_q <= 16'h0000;
        end else if (line_q && !line_i && fall_q == 16'h0000) begin
            fall_q <= cnt_q;
        end else if (!line_q && line_i && fall_q != 16'h0000 && rise_q == 16'h0000) begin
            rise_q <= cnt_q;
        end
    end
    assign t_fall_o = fall_q;
    assign t_rise_o = rise_q;
    assign ok_o = fall_q >= FALL / 2 && fall_q <= FALL * 3 / 2 && rise_q != 16'h0000
        && rise_q - fall_q >= RISE / 2 && rise_q - fall_q <= RISE * 3 / 2;
endmodule

/* File: test/selfdiag_top_test.sv */
/*
 * Bench for the self-diagnosis sequencer with a host model.
 * Assumes a pull-up on the open-drain line and shortened counts.
 */
`timescale 1ns/10ps
module selfdiag_top_test;
    // ***************************************************************
    // Setup
    // ***************************************************************
    localparam int HC = 20;
    localparam int FC = 10;
    localparam int RC = 10;
    localparam int SC = 30;
    localparam int PC = 20;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic hold = 1'b1;
    logic above = 1'b0;
    logic below = 1'b0;
    logic oe, out_o, diag, normal, pull, ok, oe_seen;
    logic [15:0] tf, tr;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int n, m, k;
    // Wired-AND of pull-up, host and sensor
    wire line = !(pull || (oe && !out_o));
    always #5 clk_i = !clk_i;
    selfdiag_top #(.HOLD_CYC(HC), .FALL_CYC(FC), .RISE_CYC(RC), .FIRST_CYC(SC),
        .PO_CYC(PC)) selfdiag_top_inst (.clk_i(clk_i), .srst_i(srst_i),
        .out_line_i(line), .field_above_op_i(above), .field_below_rel_i(below),
        .out_line_o(out_o), .out_line_oe_o(oe), .diag_active_o(diag),
        .normal_mode_o(normal));
    host_model #(.FALL(FC), .RISE(RC)) host_model_inst (.clk_i(clk_i), .hold_i(hold),
        .line_i(line), .pull_o(pull), .t_fall_o(tf), .t_rise_o(tr), .ok_o(ok));
    always @(posedge clk_i) begin
        oe_seen <= srst_i ? 1'b0 : (oe_seen || oe);
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            stop_test;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return oe;
            1: return normal;
            default: return diag;
        endcase
    endfunction
    task automatic wait_sig(input int w, input logic v, output int c);
        c = 0;
        while (pick(w) !== v && c < 200) begin
            @(negedge clk_i);
            c++;
        end
    endtask
    task automatic do_reset(input logic h);
        @(negedge clk_i);
        srst_i = 1'b1;
        hold = h;
        repeat (12) @(negedge clk_i);
        srst_i = 1'b0;
    endtask
    // ***************************************************************
    // Scenarios
    // ***************************************************************
    task automatic t_diag;
        do_reset(1'b1);
        repeat (HC + 5) @(negedge clk_i);
        chk(diag, 1'b1);
        hold = 1'b0;
        @(negedge clk_i);
        chk(line, 1'b1);
        wait_sig(0, 1'b1, n);
        chk(n + 1 >= FC / 2 && n + 1 <= FC * 3 / 2, 1'b1);
        chk({line, out_o}, 2'b00);
        wait_sig(0, 1'b0, m);
        chk(m >= RC / 2 && m <= RC * 3 / 2, 1'b1);
        chk(line, 1'b1);
        wait_sig(1, 1'b1, k);
        chk(n + m + k >= SC / 2 && n + m + k <= SC * 3 / 2, 1'b1);
        chk(ok, 1'b1);
        chk(tf, FC);
        chk(tr - tf, RC);
    endtask
    task automatic t_plain(input int early);
        do_reset(early != 0);
        repeat (early) @(negedge clk_i);
        hold = 1'b0;
        wait_sig(1, 1'b1, n);
        chk(n <= PC + 3, 1'b1);
        chk({diag, oe_seen}, 2'b00);
    endtask
    task automatic t_hyst;
        above = 1'b1;
        wait_sig(0, 1'b1, n);
        chk(n <= 3, 1'b1);
        above = 1'b0;
        repeat (5) @(negedge clk_i);
        chk(oe, 1'b1);
        below = 1'b1;
        wait_sig(0, 1'b0, n);
        chk(n <= 3, 1'b1);
        below = 1'b0;
    endtask
    task automatic stop_test;
        $display("compared=%0d errors=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        t_diag;
        t_hyst;
        t_plain(0);
        t_plain(5);
        t_hyst;
        stop_test;
    end
endmodule
